// ===== hw/vxr_pkg.sv
// Purpose: Constants for the crosspoint routing register bank
// Assumes: Two-wire serial bus, write-only control registers
// Notes:   All offsets and field positions live here
`default_nettype none

package vxr_pkg;

	// Bus address byte, select pins fill bits 7 and 6
	localparam logic [5:0] BUS_ID_BASE  = 6'h06;
	localparam int         BUS_ID_HIGH  = 7;
	localparam int         BUS_ID_LOW   = 6;
	localparam logic       WRITE_FLAG   = 1'b0;

	// Register offsets
	localparam logic [7:0] ROUTE_12_ADDR = 8'h00;
	localparam logic [7:0] ROUTE_34_ADDR = 8'h01;
	localparam logic [7:0] ROUTE_56_ADDR = 8'h02;
	localparam logic [7:0] CLAMP_ADDR    = 8'h03;
	localparam logic [7:0] GAIN_ADDR     = 8'h04;

	// Field layout and reset values
	localparam int         ODD_LSB      = 0;
	localparam int         EVEN_LSB     = 4;
	localparam int         FIELD_W      = 4;
	localparam int         GAIN_W       = 6;
	localparam logic [3:0] SOURCE_OFF   = 4'h0;
	localparam logic [7:0] ROUTE_RESET  = 8'h00;
	localparam logic [7:0] CLAMP_RESET  = 8'h00;
	localparam logic [5:0] GAIN_RESET   = 6'h00;

	// Serial bit counter
	localparam logic [3:0] LAST_BIT     = 4'h7;
	localparam logic [3:0] ACK_BIT      = 4'h8;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_DEVICE,
		LINK_REGISTER,
		LINK_DATA,
		LINK_IGNORE
	} vxr_link_type;

endpackage : vxr_pkg

`default_nettype wire

// ===== hw/vxr_route_regs.sv
// Purpose: Two-wire serial slave and routing control registers
// Assumes: Bus clock only runs during frames; straps are static
// Notes:   Serial logic runs on scl, registers on clock
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Answer 0x06, select pins set bits 7,6
// - Register address byte then data byte stored
// - Registers 0,1,2 serve output pairs
// - Low nibble odd output, high nibble even
// - Many outputs may share one input
// - One four-bit source field per output
// - Undefined addresses acknowledged and discarded
// - Clamp settings kept in separate register
// - Output enabled when source field nonzero
// - Off code powers down, output high-impedance
// - Register 3 clamp bits, one per input
// - Register 4 gain bits for six outputs
module vxr_route_regs (
	// System
	input  wire logic       clock,
	input  wire logic       resetn,
	// Serial bus
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// Address straps
	input  wire logic       busIdSelectLow,
	input  wire logic       busIdSelectHigh,
	// Output routing
	output logic [3:0]      sourceSelectOne,
	output logic [3:0]      sourceSelectTwo,
	output logic [3:0]      sourceSelectThree,
	output logic [3:0]      sourceSelectFour,
	output logic [3:0]      sourceSelectFive,
	output logic [3:0]      sourceSelectSix,
	output logic [5:0]      driveEnable,
	output logic [5:0]      driveHighZ,
	// Input and gain control
	output logic [7:0]      clampSelect,
	output logic [5:0]      gainZeroDb
);

	////////////////////////////////////////////////////////////////////////////
	// Start condition, clocked by the falling data line

	logic                   startToggle;
	logic                   startSeen;
	vxr_pkg::vxr_link_type  linkState;
	logic [3:0]             bitCount;
	logic [6:0]             shiftIn;
	logic [7:0]             regAddr;
	logic [7:0]             wrAddr;
	logic [7:0]             wrData;
	logic                   wrToggle;
	logic                   ackWanted;
	logic [2:0]             lowSync;
	logic [2:0]             highSync;
	logic [7:0]             byteIn;
	logic [7:0]             ownId;
	logic                   idLow;
	logic                   idHigh;

	always_ff @(negedge sdaIn or negedge resetn)
	begin
		if (!resetn)
			startToggle <= 1'b0;
		else if (scl)
			startToggle <= ~startToggle;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link logic on the bus clock

	// Straps only settle once a frame has clocked them in
	always_ff @(posedge scl or negedge resetn)
	begin
		if (!resetn)
		begin
			lowSync  <= 3'h0;
			highSync <= 3'h0;
			idLow    <= 1'b0;
			idHigh   <= 1'b0;
		end
		else
		begin
			lowSync  <= {lowSync[1:0], busIdSelectLow};
			highSync <= {highSync[1:0], busIdSelectHigh};
			// A level counts once the last two stages agree
			if (lowSync[1] == lowSync[2])
				idLow <= lowSync[2];
			if (highSync[1] == highSync[2])
				idHigh <= highSync[2];
		end
	end

	assign byteIn = {shiftIn, sdaIn};

	always_comb
	begin
		ownId = {2'b00, vxr_pkg::BUS_ID_BASE};
		ownId[vxr_pkg::BUS_ID_HIGH] = idHigh;
		ownId[vxr_pkg::BUS_ID_LOW]  = idLow;
	end

	always_ff @(posedge scl or negedge resetn)
	begin
		if (!resetn)
		begin
			startSeen <= 1'b0;
			linkState <= vxr_pkg::LINK_IDLE;
			bitCount  <= 4'h0;
			shiftIn   <= 7'h00;
			regAddr   <= 8'h00;
			wrAddr    <= 8'h00;
			wrData    <= 8'h00;
			wrToggle  <= 1'b0;
			ackWanted <= 1'b0;
		end
		else if (startToggle != startSeen)
		begin
			// First bit after a start, even mid-frame
			startSeen <= startToggle;
			linkState <= vxr_pkg::LINK_DEVICE;
			bitCount  <= 4'h1;
			shiftIn   <= {6'h00, sdaIn};
			ackWanted <= 1'b0;
		end
		else if (linkState != vxr_pkg::LINK_IDLE)
		begin
			if (bitCount == vxr_pkg::ACK_BIT)
			begin
				bitCount  <= 4'h0;
				ackWanted <= 1'b0;
			end
			else
			begin
				bitCount <= bitCount + 4'h1;
				shiftIn  <= byteIn[6:0];
			end
			if (bitCount == vxr_pkg::LAST_BIT)
			begin
				case (linkState)
					vxr_pkg::LINK_DEVICE:
					begin
						// Reads are never answered
						if (byteIn == ownId)
						begin
							ackWanted <= 1'b1;
							linkState <= vxr_pkg::LINK_REGISTER;
						end
						else
							linkState <= vxr_pkg::LINK_IGNORE;
					end
					vxr_pkg::LINK_REGISTER:
					begin
						ackWanted <= 1'b1;
						regAddr   <= byteIn;
						linkState <= vxr_pkg::LINK_DATA;
					end
					vxr_pkg::LINK_DATA:
					begin
						// Undefined offsets are acknowledged too
						ackWanted <= 1'b1;
						wrAddr    <= regAddr;
						wrData    <= byteIn;
						wrToggle  <= ~wrToggle;
						linkState <= vxr_pkg::LINK_IGNORE;
					end
					default:
						linkState <= vxr_pkg::LINK_IGNORE;
				endcase
			end
		end
	end

	// Acknowledge driven from falling edge to falling edge
	always_ff @(negedge scl or negedge resetn)
	begin
		if (!resetn)
			sdaOe <= 1'b0;
		else
			sdaOe <= ackWanted;
	end

	assign sdaOut = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Write event crossing into the system clock

	logic [2:0]             wrSync;
	logic                   wrTaken;
	logic                   wrEvent;
	logic [7:0]             route12;
	logic [7:0]             route34;
	logic [7:0]             route56;

	// Address and data stay put for a whole byte time after the toggle
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wrSync  <= 3'h0;
			wrTaken <= 1'b0;
		end
		else
		begin
			wrSync <= {wrSync[1:0], wrToggle};
			if (wrEvent)
				wrTaken <= wrSync[2];
		end
	end

	assign wrEvent = (wrSync[1] == wrSync[2]) && (wrSync[2] != wrTaken);

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			route12     <= vxr_pkg::ROUTE_RESET;
			route34     <= vxr_pkg::ROUTE_RESET;
			route56     <= vxr_pkg::ROUTE_RESET;
			clampSelect <= vxr_pkg::CLAMP_RESET;
			gainZeroDb  <= vxr_pkg::GAIN_RESET;
		end
		else if (wrEvent)
		begin
			if (wrAddr == vxr_pkg::ROUTE_12_ADDR)
				route12 <= wrData;
			else if (wrAddr == vxr_pkg::ROUTE_34_ADDR)
				route34 <= wrData;
			else if (wrAddr == vxr_pkg::ROUTE_56_ADDR)
				route56 <= wrData;
			else if (wrAddr == vxr_pkg::CLAMP_ADDR)
				clampSelect <= wrData;
			else if (wrAddr == vxr_pkg::GAIN_ADDR)
				gainZeroDb <= wrData[vxr_pkg::GAIN_W-1:0];
		end
	end

	// No conflict check: fields are independent
	assign sourceSelectOne   = route12[vxr_pkg::ODD_LSB +: vxr_pkg::FIELD_W];
	assign sourceSelectTwo   = route12[vxr_pkg::EVEN_LSB +: vxr_pkg::FIELD_W];
	assign sourceSelectThree = route34[vxr_pkg::ODD_LSB +: vxr_pkg::FIELD_W];
	assign sourceSelectFour  = route34[vxr_pkg::EVEN_LSB +: vxr_pkg::FIELD_W];
	assign sourceSelectFive  = route56[vxr_pkg::ODD_LSB +: vxr_pkg::FIELD_W];
	assign sourceSelectSix   = route56[vxr_pkg::EVEN_LSB +: vxr_pkg::FIELD_W];

	// Off code is the only disabled encoding
	function automatic logic sourceActive(input logic [3:0] code);
		return code != vxr_pkg::SOURCE_OFF;
	endfunction : sourceActive

	always_comb
	begin
		driveEnable[0] = sourceActive(sourceSelectOne);
		driveEnable[1] = sourceActive(sourceSelectTwo);
		driveEnable[2] = sourceActive(sourceSelectThree);
		driveEnable[3] = sourceActive(sourceSelectFour);
		driveEnable[4] = sourceActive(sourceSelectFive);
		driveEnable[5] = sourceActive(sourceSelectSix);
	end

	assign driveHighZ = ~driveEnable;

endmodule : vxr_route_regs

`default_nettype wire

// ===== dv/vxr_route_regs_props.sv
// Purpose: Checker for the routing register bank
// Assumes: Registers on the system clock, ack on the link clock
// Notes:   Ack slot checked in link clock periods
`default_nettype none

module vxr_route_regs_props (
	// System
	input wire logic       clock,
	input wire logic       resetn,
	// Serial bus
	input wire logic       scl,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic       busIdSelectLow,
	input wire logic       busIdSelectHigh,
	// Routing and control
	input wire logic [3:0] sourceSelectOne,
	input wire logic [3:0] sourceSelectTwo,
	input wire logic [3:0] sourceSelectThree,
	input wire logic [3:0] sourceSelectFour,
	input wire logic [3:0] sourceSelectFive,
	input wire logic [3:0] sourceSelectSix,
	input wire logic [5:0] driveEnable,
	input wire logic [5:0] driveHighZ,
	input wire logic [7:0] clampSelect,
	input wire logic [5:0] gainZeroDb
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] route;
	assign route = {sourceSelectSix, sourceSelectFive, sourceSelectFour,
		sourceSelectThree, sourceSelectTwo, sourceSelectOne};
	// Ack slot is one link clock wide, whatever the link rate
	sequence ackSlot;
		sdaOe ##1 !sdaOe;
	endsequence
	////////////////////////////////////////////////////////////
	highz_inverse_a: assert property (@(posedge clock) disable iff (!resetn)
		driveHighZ == ~driveEnable) else $error("high-z not inverse of enable");
	enable_map_a: assert property (@(posedge clock) disable iff (!resetn)
		driveEnable[0] == |sourceSelectOne && driveEnable[5] == |sourceSelectSix)
		else $error("enable mismatch");
	ack_low_a: assert property (@(posedge scl) disable iff (!resetn)
		sdaOe |-> !sdaOut) else $error("ack does not pull data low");
	ack_slot_a: assert property (@(negedge scl) disable iff (!resetn)
		$rose(sdaOe) |-> ackSlot) else $error("ack slot length wrong");
	route_keeps_clamp_a: assert property (@(posedge clock) disable iff (!resetn)
		$changed(route) |-> $stable(clampSelect) && $stable(gainZeroDb))
		else $error("clamp moved");
	clamp_keeps_route_a: assert property (@(posedge clock) disable iff (!resetn)
		$changed(clampSelect) |-> $stable(route)) else $error("route moved");
	pair_apart_a: assert property (@(posedge clock) disable iff (!resetn)
		$changed(route[7:0]) |-> $stable(route[23:8])) else $error("other pair moved");
	reset_off_a: assert property (@(posedge clock) disable iff (!resetn)
		$rose(resetn) |-> route == 24'h00_0000) else $error("route not off after reset");
endmodule : vxr_route_regs_props

bind vxr_route_regs vxr_route_regs_props chk (.clock, .resetn, .scl, .sdaIn, .sdaOut,
	.sdaOe, .busIdSelectLow, .busIdSelectHigh, .sourceSelectOne, .sourceSelectTwo,
	.sourceSelectThree, .sourceSelectFour, .sourceSelectFive, .sourceSelectSix,
	.driveEnable, .driveHighZ, .clampSelect, .gainZeroDb);

`default_nettype wire

// ===== dv/vxr_bus_master.sv
// Purpose: Serial bus master model
// Assumes: Pull-up on data, clock idles high
// Notes:   One register write per frame
`default_nettype none

module vxr_bus_master (
	// Serial bus
	output logic     scl,
	output logic     sdaIn,
	input wire logic sdaOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drive = 1'b1;
	assign sdaIn = drive & ~sdaOe;
	initial scl = 1'b1;
	task automatic sendByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--)
		begin
			#20 drive = (i < 0) ? 1'b1 : b[i];
			#20 scl = 1'b1;
			if (i < 0)
				ack = ~sdaIn;
			#40 scl = 1'b0;
		end
	endtask : sendByte
	// Device byte, register byte, data byte
	task automatic write(input logic [23:0] frame, output logic [2:0] acks);
		#20 drive = 1'b0;
		#40 scl = 1'b0;
		for (int k = 2; k >= 0; k--)
			sendByte(frame[8*k+:8], acks[k]);
		#20 drive = 1'b0;
		#20 scl = 1'b1;
		#20 drive = 1'b1;
	endtask : write
endmodule : vxr_bus_master

`default_nettype wire

// ===== dv/testbench.sv
// Purpose: Bench for the routing register bank
// Assumes: Writes land within six clocks
// Notes:   Registers are write-only, so a shadow is kept
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic       scl;
	logic       sdaIn;
	logic       sdaOut;
	logic       sdaOe;
	logic [1:0] strap = 2'b00;
	wire logic [5:0][3:0] src;
	logic [5:0] driveEnable;
	logic [5:0] driveHighZ;
	logic [7:0] clampSelect;
	logic [5:0] gainZeroDb;
	logic [7:0] shadow [5];
	int         err_count = 0;
	int         comparisons = 0;
	initial forever #20 clock = ~clock;
	vxr_route_regs DUT (.clock, .resetn, .scl, .sdaIn, .sdaOut, .sdaOe,
		.busIdSelectLow(strap[0]), .busIdSelectHigh(strap[1]),
		.sourceSelectOne(src[0]), .sourceSelectTwo(src[1]), .sourceSelectThree(src[2]),
		.sourceSelectFour(src[3]), .sourceSelectFive(src[4]), .sourceSelectSix(src[5]),
		.driveEnable, .driveHighZ, .clampSelect, .gainZeroDb);
	vxr_bus_master master (.scl, .sdaIn, .sdaOe);
	////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Straps change only under reset
	task automatic doReset(input logic [1:0] s);
		@(posedge clock);
		#1 resetn = 1'b0;
		strap = s;
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (5) @(posedge clock);
		#1 resetn = 1'b1;
	endtask : doReset
	task automatic expState();
		logic [3:0] f;
		for (int i = 0; i < 6; i++)
		begin
			f = shadow[i/2][4*(i%2)+:4];
			check(src[i], f);
			check(driveEnable[i], |f);
			check(driveHighZ[i], ~|f);
		end
		check(clampSelect, shadow[3]);
		check(gainZeroDb, shadow[4][5:0]);
	endtask : expState
	task automatic wr(input logic [7:0] dev, input logic [7:0] regA,
		input logic [7:0] dat, input logic [2:0] expAck);
		logic [2:0] acks;
		@(posedge clock);
		#1 master.write({dev, regA, dat}, acks);
		check(acks, expAck);
		repeat (6) @(posedge clock);
		if (expAck == 3'b111 && regA < 8'h05)
			shadow[regA[2:0]] = dat;
		#1 expState();
	endtask : wr
	task automatic final_report();
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	initial
	begin
		for (int s = 0; s < 4; s++)
		begin
			doReset(s[1:0]);
			expState();
			wr({s[1:0], 6'h06}, 8'h00, 8'h81, 3'b111);
			wr({~s[1:0], 6'h06}, 8'h00, 8'h22, 3'b000);
		end
		wr(8'hC6, 8'h01, 8'h11, 3'b111);
		wr(8'hC6, 8'h02, 8'h08, 3'b111);
		wr(8'hC6, 8'h03, 8'hA5, 3'b111);
		wr(8'hC6, 8'h04, 8'hFF, 3'b111);
		wr(8'hC6, 8'h00, 8'h70, 3'b111);
		wr(8'hC6, 8'h05, 8'h33, 3'b111);
		wr(8'hC6, 8'hFF, 8'h44, 3'b111);
		wr(8'hC7, 8'h00, 8'h55, 3'b000);
		final_report();
	end
endmodule : testbench

`default_nettype wire
